// >>> wts_seq.sv
// Trigger and playback sequencer top
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Single: one repetition per accepted trigger
// - Single: triggers during playback discarded
// - Burst: programmed repetitions per trigger
// - Burst count up to 4096
// - Burst: triggers ignored until count done
// - Gated: start on gate leading edge
// - Gated: finish current cycle after trailing edge
// - Latency: five clocks plus fixed path
// - Delay counted in whole sample clocks
// - Panel step changes delay one clock
// - Inherent delay constant, readable by software
// - Manual, external or remote trigger sources
// - Segments shorter than 64 rejected
// - Segment length in single-point steps
// - Addressing spans 256k or 1M
module wts_seq import wts_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trigger sources and panel delay steps
  input wire logic manual_trig,
  input wire logic ext_trig,
  input wire logic delay_up,
  input wire logic delay_down,
  // Sample memory
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [SAMPLE_W-1:0] mem_data,
  // Converter side
  output logic [SAMPLE_W-1:0] dac_data,
  output logic dac_valid,
  output logic busy
);
  logic [31:0] ctrl_q, ctrl_d;
  logic [ADDR_W-1:0] seg_start_q, seg_start_d;
  logic [ADDR_W-1:0] seg_len_q, seg_len_d;
  logic [BURST_W-1:0] burst_q, burst_d;
  logic [DELAY_W-1:0] delay_q, delay_d;
  logic [31:0] rdata_q, rdata_d;
  logic len_err_q, len_err_d;
  logic trig_seen_q, trig_seen_d;
  logic ext_q, man_q, gate_q;

  wts_state_t state_q, state_d;
  logic [DELAY_W-1:0] dcnt_q, dcnt_d;
  logic [ADDR_W-1:0] pos_q, pos_d;
  logic [BURST_W-1:0] reps_q, reps_d;
  logic rd_valid_q, rd_valid_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;

  wts_mode_t mode;
  logic slope_neg, big_mem, run_en, ext_lvl, ext_edge, man_edge, cmd_trig;
  logic trig, gate_rise, gate_fall, last_pt, seg_ok;
  wts_sample_t pipe_in, pipe_out;

  assign mode = wts_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign slope_neg = ctrl_q[CTRL_SLOPE_BIT];
  assign big_mem = ctrl_q[CTRL_BIGMEM_BIT];
  assign run_en = ctrl_q[CTRL_RUN_BIT];
  assign ext_lvl = ext_trig ^ slope_neg;
  assign ext_edge = ext_lvl & ~ext_q;
  assign man_edge = manual_trig & ~man_q;
  assign cmd_trig = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_TRIG_BIT];
  assign trig = run_en & (ext_edge | man_edge | cmd_trig);
  // Gate follows the external input level, respecting the chosen polarity
  assign gate_rise = ext_lvl & ~gate_q;
  assign gate_fall = ~ext_lvl & gate_q;
  assign seg_ok = seg_len_q >= MIN_SEG_LEN;
  assign last_pt = pos_q == seg_len_q - 20'h00001;

  // Register and panel updates
  always_comb begin
    ctrl_d = ctrl_q;
    seg_start_d = seg_start_q;
    seg_len_d = seg_len_q;
    burst_d = burst_q;
    delay_d = delay_q;
    len_err_d = len_err_q;
    rdata_d = 32'h0000_0000;
    trig_seen_d = trig_seen_q | trig;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: ctrl_d = reg_wdata;
        REG_SEG_START: seg_start_d = wts_clamp_depth(reg_wdata[ADDR_W-1:0], big_mem);
        REG_SEG_LEN: begin
          // Short lengths are refused so playback never sees them
          if (reg_wdata[ADDR_W-1:0] >= MIN_SEG_LEN) begin
            seg_len_d = reg_wdata[ADDR_W-1:0];
          end else begin
            len_err_d = 1'b1;
          end
        end
        REG_BURST: begin
          if (reg_wdata[BURST_W-1:0] != '0 && reg_wdata[BURST_W-1:0] <= BURST_MAX) begin
            burst_d = reg_wdata[BURST_W-1:0];
          end
        end
        REG_DELAY: delay_d = reg_wdata;
        REG_CMD: begin
          // Saturate like the panel path so a step never wraps the delay
          if (reg_wdata[CMD_INC_BIT] && delay_q != '1) delay_d = delay_q + 32'h1;
          if (reg_wdata[CMD_DEC_BIT] && delay_q != '0) delay_d = delay_q - 32'h1;
        end
        default: ;
      endcase
    end
    if (delay_up && delay_q != '1) delay_d = delay_q + 32'h1;
    else if (delay_down && delay_q != '0) delay_d = delay_q - 32'h1;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_SEG_START: rdata_d = 32'(seg_start_q);
        REG_SEG_LEN: rdata_d = 32'(seg_len_q);
        REG_BURST: rdata_d = 32'(burst_q);
        REG_DELAY: rdata_d = delay_q;
        REG_STATUS: rdata_d = {26'h0, len_err_q, trig_seen_q, 2'b00, state_q};
        // Constant fixed latency so software can subtract it
        REG_LATENCY: rdata_d = 32'(PIPE_STAGES + PATH_DELAY_CYC);
        default: rdata_d = 32'h0000_0000;
      endcase
      if (reg_addr == REG_STATUS) begin
        len_err_d = 1'b0;
        trig_seen_d = trig;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      seg_start_q <= '0;
      seg_len_q <= MIN_SEG_LEN;
      burst_q <= 13'h0001;
      delay_q <= '0;
      rdata_q <= '0;
      len_err_q <= 1'b0;
      trig_seen_q <= 1'b0;
      ext_q <= 1'b0;
      man_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      seg_start_q <= seg_start_d;
      seg_len_q <= seg_len_d;
      burst_q <= burst_d;
      delay_q <= delay_d;
      rdata_q <= rdata_d;
      len_err_q <= len_err_d;
      trig_seen_q <= trig_seen_d;
      ext_q <= ext_lvl;
      man_q <= manual_trig;
      gate_q <= ext_lvl;
    end
  end

  assign reg_rdata = rdata_q;

  // Playback sequencer
  always_comb begin
    state_d = state_q;
    dcnt_d = dcnt_q;
    pos_d = pos_q;
    reps_d = reps_q;
    unique case (state_q)
      WTS_IDLE: begin
        pos_d = '0;
        if (run_en && seg_ok) begin
          if (mode == WTS_CONT) begin
            state_d = WTS_PLAY;
          end else if ((mode == WTS_GATED) ? gate_rise : trig) begin
            reps_d = (mode == WTS_BURST) ? burst_q : 13'h0001;
            dcnt_d = delay_q;
            state_d = (delay_q == '0) ? WTS_PLAY : WTS_DELAY;
          end
        end
      end
      WTS_DELAY: begin
        // Triggers in this state are simply dropped
        dcnt_d = dcnt_q - 32'h1;
        if (dcnt_q == 32'h1) state_d = WTS_PLAY;
      end
      WTS_PLAY: begin
        // Triggers never restart or queue here
        pos_d = pos_q + 20'h00001;
        if (last_pt) begin
          pos_d = '0;
          unique case (mode)
            WTS_CONT: state_d = run_en ? WTS_PLAY : WTS_IDLE;
            WTS_GATED: state_d = (ext_lvl && run_en) ? WTS_PLAY : WTS_IDLE;
            default: begin
              reps_d = reps_q - 13'h0001;
              if (reps_q == 13'h0001) state_d = WTS_IDLE;
            end
          endcase
        end
      end
      default: state_d = WTS_IDLE;
    endcase
    rd_valid_d = state_q == WTS_PLAY;
    rd_addr_d = wts_clamp_depth(seg_start_q + pos_q, big_mem);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= WTS_IDLE;
      dcnt_q <= '0;
      pos_q <= '0;
      reps_q <= '0;
      rd_valid_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      state_q <= state_d;
      dcnt_q <= dcnt_d;
      pos_q <= pos_d;
      reps_q <= reps_d;
      rd_valid_q <= rd_valid_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  assign mem_addr = rd_addr_q;
  assign busy = state_q != WTS_IDLE;
  assign pipe_in = '{valid: rd_valid_q, addr: rd_addr_q, data: mem_data};

  // Fixed depth keeps trigger latency deterministic per rate
  wts_pipe #(.STAGES(PIPE_STAGES)) u_pipe (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_s(pipe_in),
    .out_s(pipe_out)
  );

  assign dac_data = pipe_out.data;
  assign dac_valid = pipe_out.valid;

  property p_single_one_rep;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_PLAY && last_pt && mode == WTS_SINGLE) |=> state_q == WTS_IDLE;
  endproperty
  a_single_one_rep: assert property (p_single_one_rep) else $error("single did not stop");

  property p_no_restart;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_PLAY && !last_pt && trig) |=> pos_q == $past(pos_q) + 20'h00001;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("trigger restarted play");

  property p_burst_load;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_IDLE && run_en && seg_ok && mode == WTS_BURST && trig)
      |=> reps_q == $past(burst_q);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("burst count not loaded");

  property p_burst_range;
    @(posedge sys_clk) disable iff (!resetn)
    burst_q != '0 && burst_q <= BURST_MAX;
  endproperty
  a_burst_range: assert property (p_burst_range) else $error("burst count out of range");

  property p_gate_start;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_IDLE && mode == WTS_GATED && run_en && seg_ok && gate_rise && delay_q == '0)
      |=> state_q == WTS_PLAY;
  endproperty
  a_gate_start: assert property (p_gate_start) else $error("gate did not start");

  property p_gate_finish;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_PLAY && mode == WTS_GATED && !last_pt && $stable(mode))
      |=> state_q == WTS_PLAY;
  endproperty
  a_gate_finish: assert property (p_gate_finish) else $error("gated cycle truncated");

  sequence s_play_issue;
    rd_valid_q ##0 rd_valid_q;
  endsequence
  property p_latency;
    @(posedge sys_clk) disable iff (!resetn)
    s_play_issue |-> ##5 dac_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("pipeline depth wrong");

  property p_seg_min;
    @(posedge sys_clk) disable iff (!resetn)
    seg_len_q >= MIN_SEG_LEN;
  endproperty
  a_seg_min: assert property (p_seg_min) else $error("segment shorter than minimum");

  property p_delay_count;
    @(posedge sys_clk) disable iff (!resetn)
    (state_q == WTS_DELAY && dcnt_q > 32'h1) |=> state_q == WTS_DELAY && dcnt_q == $past(dcnt_q) - 32'h1;
  endproperty
  a_delay_count: assert property (p_delay_count) else $error("delay miscounted");
endmodule // wts_seq

// >>> wts_pkg.sv
// Package for the waveform trigger sequencer: constants, modes, register map
package wts_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam logic [ADDR_W-1:0] DEPTH_STD = 20'h3ffff;
  localparam logic [ADDR_W-1:0] DEPTH_OPT = 20'hfffff;
  localparam logic [ADDR_W-1:0] MIN_SEG_LEN = 20'h00040;
  localparam int unsigned BURST_W = 13;
  localparam logic [BURST_W-1:0] BURST_MAX = 13'h1000;
  localparam int unsigned DELAY_W = 32;
  localparam int unsigned PIPE_STAGES = 5;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned PATH_DELAY_PS = 35000;
  localparam int unsigned PATH_DELAY_CYC = PATH_DELAY_PS / CLK_PERIOD_PS;
  localparam int unsigned SAMPLE_W = 8;

  localparam int unsigned REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_SEG_START = 4'h1;
  localparam logic [REG_AW-1:0] REG_SEG_LEN = 4'h2;
  localparam logic [REG_AW-1:0] REG_BURST = 4'h3;
  localparam logic [REG_AW-1:0] REG_DELAY = 4'h4;
  localparam logic [REG_AW-1:0] REG_CMD = 4'h5;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h6;
  localparam logic [REG_AW-1:0] REG_LATENCY = 4'h7;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SLOPE_BIT = 2;
  localparam int unsigned CTRL_BIGMEM_BIT = 3;
  localparam int unsigned CTRL_RUN_BIT = 4;
  // Command register bits
  localparam int unsigned CMD_TRIG_BIT = 0;
  localparam int unsigned CMD_INC_BIT = 1;
  localparam int unsigned CMD_DEC_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    WTS_CONT = 2'b00,
    WTS_SINGLE = 2'b01,
    WTS_BURST = 2'b10,
    WTS_GATED = 2'b11
  } wts_mode_t;

  typedef enum logic [1:0] {
    WTS_IDLE = 2'b00,
    WTS_DELAY = 2'b01,
    WTS_PLAY = 2'b10
  } wts_state_t;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wts_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [SAMPLE_W-1:0] data;
  } wts_sample_t;

  function automatic logic [ADDR_W-1:0] wts_clamp_depth(input logic [ADDR_W-1:0] v,
                                                         input logic big);
    logic [ADDR_W-1:0] lim;
    lim = big ? DEPTH_OPT : DEPTH_STD;
    return (v > lim) ? lim : v;
  endfunction
endpackage

// >>> wts_pipe.sv
// Fixed-length sample pipeline toward the output converter
`timescale 1ns/1ps
module wts_pipe import wts_pkg::*; #(
  parameter int unsigned STAGES = PIPE_STAGES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Stream
  input wire wts_sample_t in_s,
  output wts_sample_t out_s
);
  wts_sample_t stage_q [STAGES];
  wts_sample_t stage_d [STAGES];

  always_comb begin
    stage_d[0] = in_s;
    for (int i = 1; i < STAGES; i++) begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= stage_d[i];
      end
    end
  end

  assign out_s = stage_q[STAGES-1];
endmodule // wts_pipe

// >>> wts_mem_model.sv
// Sample memory model on the far side of the sequencer
`timescale 1ns/1ps
module wts_mem_model import wts_pkg::*; (
  // Memory port
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic [SAMPLE_W-1:0] mem_data
);
  // Same-cycle read; pattern follows the address so a wrong fetch shows
  assign mem_data = mem_addr[7:0] ^ 8'h5a;
endmodule // wts_mem_model

// >>> wts_seq_bench.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
module wts_seq_bench import wts_pkg::*; ();
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic manual_trig = 1'b0;
  logic ext_trig = 1'b0;
  logic delay_up = 1'b0;
  logic delay_down = 1'b0;
  logic [ADDR_W-1:0] mem_addr;
  logic [SAMPLE_W-1:0] mem_data;
  logic [SAMPLE_W-1:0] dac_data;
  logic dac_valid;
  logic busy;
  logic b_q = 1'b0;
  logic v_q = 1'b0;
  logic [SAMPLE_W-1:0] first_d = '0;
  int err_count = 0;
  int checks = 0;
  int busy_cnt = 0;
  int val_cnt = 0;
  int lat = 0;
  int first_lat = 0;

  always #4 sys_clk = ~sys_clk;

  wts_seq DUT (
    .sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .manual_trig(manual_trig), .ext_trig(ext_trig),
    .delay_up(delay_up), .delay_down(delay_down), .mem_addr(mem_addr),
    .mem_data(mem_data), .dac_data(dac_data), .dac_valid(dac_valid), .busy(busy)
  );
  wts_mem_model u_mem (.mem_addr(mem_addr), .mem_data(mem_data));

  // Counts busy and output cycles; latency from busy rise to first sample
  always @(posedge sys_clk) begin
    b_q <= busy;
    v_q <= dac_valid;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (dac_valid === 1'b1) val_cnt <= val_cnt + 1;
    if (busy === 1'b1 && b_q !== 1'b1) lat <= 1;
    else lat <= lat + 1;
    if (dac_valid === 1'b1 && v_q !== 1'b1) begin
      first_lat <= lat;
      first_d <= dac_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [REG_AW-1:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // 0 pushbutton, 1 external pulse away from idle level, 2 remote command
  task automatic fire(input int k);
    if (k == 2) wr(REG_CMD, 32'h1);
    else begin
      @(posedge sys_clk);
      if (k == 0) manual_trig <= 1'b1;
      else ext_trig <= ~ext_trig;
      repeat (3) @(posedge sys_clk);
      if (k == 0) manual_trig <= 1'b0;
      else ext_trig <= ~ext_trig;
    end
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 10000 && busy !== 1'b0; n++) @(posedge sys_clk);
    repeat (10) @(posedge sys_clk);
  endtask

  // Trigger, optional stray trigger mid-play, then judge counts and latency
  task automatic meas(input int k, input int dly, input int bl, input int xk);
    int b0;
    int v0;
    b0 = busy_cnt;
    v0 = val_cnt;
    fire(k);
    repeat (dly + 12) @(posedge sys_clk);
    if (xk >= 0) fire(xk);
    wait_idle();
    chk(busy_cnt - b0, dly + bl);
    chk(val_cnt - v0, bl);
    chk(first_lat, dly + 6);
    // Start address low byte is zero
    chk({24'h0, first_d}, 32'h5a);
  endtask

  task automatic t_reset();
    rchk(REG_CTRL, CTRL_RESET);
    rchk(REG_SEG_LEN, 32'h40);
    rchk(REG_BURST, 32'h1);
    rchk(REG_DELAY, 32'h0);
    rchk(REG_LATENCY, 32'h9);
    rchk(4'hf, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_regs();
    wr(REG_SEG_LEN, 32'h3f);
    rchk(REG_SEG_LEN, 32'h40);
    rchk(REG_STATUS, 32'h20);
    rchk(REG_STATUS, 32'h0);
    wr(REG_SEG_LEN, 32'h41);
    rchk(REG_SEG_LEN, 32'h41);
    wr(REG_SEG_LEN, 32'h40);
    wr(REG_BURST, 32'h1001);
    rchk(REG_BURST, 32'h1);
    wr(REG_BURST, 32'h1000);
    rchk(REG_BURST, 32'h1000);
    wr(REG_BURST, 32'h0);
    rchk(REG_BURST, 32'h1000);
    wr(REG_DELAY, 32'hffffffff);
    rchk(REG_DELAY, 32'hffffffff);
    wr(REG_SEG_START, 32'h40000);
    rchk(REG_SEG_START, 32'h3ffff);
    wr(REG_CTRL, 32'h8);
    wr(REG_SEG_START, 32'hfffff);
    rchk(REG_SEG_START, 32'hfffff);
    wr(REG_CTRL, 32'h0);
    wr(REG_SEG_START, 32'h100);
    $display("register access done");
  endtask

  task automatic t_delay();
    wr(REG_DELAY, 32'h3);
    @(posedge sys_clk);
    delay_up <= 1'b1;
    @(posedge sys_clk);
    delay_up <= 1'b0;
    rchk(REG_DELAY, 32'h4);
    wr(REG_CMD, 32'h2);
    rchk(REG_DELAY, 32'h5);
    wr(REG_CMD, 32'h4);
    @(posedge sys_clk);
    delay_down <= 1'b1;
    @(posedge sys_clk);
    delay_down <= 1'b0;
    rchk(REG_DELAY, 32'h3);
    $display("delay stepping done");
  endtask

  task automatic t_single();
    wr(REG_CTRL, 32'h11);
    meas(2, 3, 64, 1);
    wr(REG_DELAY, 32'h0);
    meas(0, 0, 64, 0);
    // Run off while the idle level flips, so no stray edge is taken
    wr(REG_CTRL, 32'h1);
    @(posedge sys_clk);
    ext_trig <= 1'b1;
    wr(REG_CTRL, 32'h15);
    meas(1, 0, 64, 2);
    // Accepted triggers leave a sticky flag that one status read clears
    rchk(REG_STATUS, 32'h10);
    rchk(REG_STATUS, 32'h0);
    $display("single mode done");
  endtask

  task automatic t_burst();
    wr(REG_CTRL, 32'h0);
    @(posedge sys_clk);
    ext_trig <= 1'b0;
    wr(REG_BURST, 32'h3);
    wr(REG_CTRL, 32'h12);
    meas(0, 0, 192, 0);
    $display("burst mode done");
  endtask

  task automatic t_gate();
    int b0;
    int v0;
    wr(REG_CTRL, 32'h13);
    b0 = busy_cnt;
    v0 = val_cnt;
    @(posedge sys_clk);
    ext_trig <= 1'b1;
    // Gate falls inside the second repetition
    repeat (100) @(posedge sys_clk);
    ext_trig <= 1'b0;
    wait_idle();
    chk(busy_cnt - b0, 128);
    chk(val_cnt - v0, 128);
    $display("gated mode done");
  endtask

  task automatic t_cont();
    int b0;
    int v0;
    wr(REG_CTRL, 32'h10);
    repeat (20) @(posedge sys_clk);
    b0 = busy_cnt;
    v0 = val_cnt;
    fire(0);
    repeat (196) @(posedge sys_clk);
    chk(busy_cnt - b0, 200);
    chk(val_cnt - v0, 200);
    wr(REG_CTRL, 32'h0);
    wait_idle();
    chk({31'h0, busy}, 32'h0);
    $display("continuous mode done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_delay();
    t_single();
    t_burst();
    t_gate();
    t_cont();
    close_out();
  end

  // Whole run needs under two thousand cycles; this is ample margin
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule // wts_seq_bench
